/* File: logic/pcsd_top.sv */
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Straps sampled once after reset release, held until next reset.
// - Bus-style strap high selects simple mode two, low mode one.
// - Interface-select straps 111 choose simple host family.
// - Endian strap high big-endian, low little-endian host bytes.
// - Buffered: upper bits ignored, 128K window aliased 128 times.
// - Direct: window aliased 512 times from 64000000h or 68000000h.
// - Mode one accepts strobes asynchronous to bus clock.
// - Memory at 0..13FFFh, registers at 1FFE0h..1FFFFh in window.
// - Active-low wait stalls host until arbitration with refresh done.
module pcsd_top
   import pcsd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        bus_style_strap,
   input  wire logic [3:0]  configuration_straps,
   input  wire logic        host_cs_n,
   input  wire logic        host_rd_n,
   input  wire logic        host_we0_n,
   input  wire logic        host_we1_n,
   input  wire logic [25:0] host_addr,
   input  wire logic [15:0] host_data_in,
   output var  logic [15:0] host_data_out,
   output logic             host_data_oe,
   output logic             host_wait_n,
   input  wire logic        host_bus_clock,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output var  logic [31:0] avs_readdata,
   output logic             avs_waitrequest
);
   // ==========================================
   // Strap capture
   logic [4:0]  strap_s1_reg, strap_s2_reg, strap_reg, strap_next;
   logic        strap_done_reg, strap_done_next;
   logic [1:0]  strap_age_reg, strap_age_next;
   logic        strap_ripe;
   // Sync flops reset to zero; wait until the pin value reaches the second
   assign strap_ripe = (strap_age_reg == 2'(PCSD_STRAP_SETTLE));
   always_comb
   begin
      strap_next      = strap_reg;
      strap_done_next = strap_done_reg || strap_ripe;
      strap_age_next  = strap_ripe ? strap_age_reg : strap_age_reg + 2'h1;
      if (strap_ripe && !strap_done_reg)
         strap_next = strap_s2_reg;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_s1_reg   <= 5'h00;
         strap_s2_reg   <= 5'h00;
         strap_reg      <= 5'h00;
         strap_done_reg <= 1'b0;
         strap_age_reg  <= 2'h0;
      end
      else
      begin
         strap_s1_reg   <= {bus_style_strap, configuration_straps};
         strap_s2_reg   <= strap_s1_reg;
         strap_reg      <= strap_next;
         strap_done_reg <= strap_done_next;
         strap_age_reg  <= strap_age_next;
      end
   end
   logic big_endian, mode_two, simple_family;
   assign big_endian    = strap_reg[PCSD_ENDIAN_BIT];
   assign simple_family = (strap_reg[2:0] == PCSD_IFSEL_SIMPLE);
   assign mode_two      = strap_reg[4];

   // ==========================================
   // Strobe synchroniser
   // Host strobes and bus clock are foreign to clk; two flops each
   logic [37:0] hs1_reg, hs2_reg;
   logic [37:0] hs_raw;
   assign hs_raw = {host_bus_clock, host_cs_n, host_rd_n, host_we0_n,
                    host_we1_n, host_addr[16:0], host_data_in};
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs1_reg <= {5'h1F, 33'h0};
         hs2_reg <= {5'h1F, 33'h0};
      end
      else
      begin
         hs1_reg <= hs_raw;
         hs2_reg <= hs1_reg;
      end
   end
   logic cs_s, rd_s, we0_s, we1_s;
   logic [16:0] win_addr;
   logic [15:0] data_s;
   assign cs_s   = ~hs2_reg[36];
   assign rd_s   = ~hs2_reg[35];
   assign we0_s  = ~hs2_reg[34];
   assign we1_s  = ~hs2_reg[33];
   assign data_s = hs2_reg[15:0];
   // Upper address ignored: only A16..A0 decoded, so window aliases
   assign win_addr = hs2_reg[32:16];

   function automatic logic [1:0] pcsd_region(input logic [16:0] a);
      if (a <= PCSD_MEM_LAST)
         pcsd_region = 2'h1;
      else if (a >= PCSD_REG_FIRST)
         pcsd_region = 2'h2;
      else
         pcsd_region = 2'h0;
   endfunction : pcsd_region

   // ==========================================
   // Access sequencer with refresh arbitration
   pcsd_state_t state_reg, state_next;
   logic [4:0]  rcnt_reg, rcnt_next;
   logic [15:0] dout_reg, dout_next;
   logic [15:0] regs_reg [PCSD_REG_WORDS];
   logic [15:0] regs_next [PCSD_REG_WORDS];
   logic        is_write, is_read, refresh_busy, access_on;
   logic [1:0]  be;
   logic [15:0] wdata_sw, mem_rd_sw;
   logic [1:0]  ctrl_reg, ctrl_next;
   pcsd_mem_if  mif ();
   pcsd_mem u_mem
   (
      .clk (clk),
      .mem (mif)
   );
   // Mode two: we1 is high byte enable for both directions
   assign is_write  = we0_s || (!mode_two && we1_s);
   assign is_read   = rd_s;
   assign be        = mode_two ? {we1_s, 1'b1} : (is_write ? {we1_s, we0_s} : 2'h3);
   assign access_on = cs_s && simple_family && !ctrl_reg[0] && (is_read || is_write);
   assign refresh_busy = (rcnt_reg < 5'(PCSD_REFRESH_LEN));
   assign wdata_sw  = big_endian ? {data_s[7:0], data_s[15:8]} : data_s;
   assign mem_rd_sw = big_endian ? {mif.rdata[7:0], mif.rdata[15:8]} : mif.rdata;
   assign mif.addr  = win_addr;
   assign mif.wdata = wdata_sw;
   assign mif.be    = be;
   assign mif.we    = (state_reg == PCSD_ARB) && !refresh_busy && is_write
                      && (pcsd_region(win_addr) == 2'h1);
   always_comb
   begin
      state_next = state_reg;
      dout_next  = dout_reg;
      rcnt_next  = (rcnt_reg == 5'(PCSD_REFRESH_PERIOD - 1)) ? 5'h00 : rcnt_reg + 5'h01;
      for (int i = 0; i < PCSD_REG_WORDS; i++)
         regs_next[i] = regs_reg[i];
      unique case (state_reg)
         PCSD_IDLE:
            if (access_on)
               state_next = PCSD_ARB;
         PCSD_ARB:
            if (!refresh_busy)
            begin
               if (is_write && pcsd_region(win_addr) == 2'h2)
               begin
                  if (be[0])
                     regs_next[win_addr[4:1]][7:0] = wdata_sw[7:0];
                  if (be[1])
                     regs_next[win_addr[4:1]][15:8] = wdata_sw[15:8];
               end
               state_next = PCSD_DONE;
            end
         PCSD_DONE:
         begin
            unique case (pcsd_region(win_addr))
               2'h1:    dout_next = mem_rd_sw;
               2'h2:    dout_next = big_endian ? {regs_reg[win_addr[4:1]][7:0], regs_reg[win_addr[4:1]][15:8]}
                                               : regs_reg[win_addr[4:1]];
               default: dout_next = 16'h0000;
            endcase
            state_next = PCSD_RELS;
         end
         PCSD_RELS:
            if (!cs_s || !(is_read || is_write))
               state_next = PCSD_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= PCSD_IDLE;
         rcnt_reg  <= 5'h00;
         dout_reg  <= 16'h0000;
         for (int i = 0; i < PCSD_REG_WORDS; i++)
            regs_reg[i] <= 16'h0000;
      end
      else
      begin
         state_reg <= state_next;
         rcnt_reg  <= rcnt_next;
         dout_reg  <= dout_next;
         regs_reg  <= regs_next;
      end
   end
   // Wait held low from access until data ready or write accepted
   assign host_wait_n   = !(access_on && (state_reg == PCSD_IDLE || state_reg == PCSD_ARB
                           || state_reg == PCSD_DONE));
   assign host_data_out = dout_reg;
   assign host_data_oe  = (state_reg == PCSD_RELS) && is_read && cs_s;

   // ==========================================
   // Avalon-MM slave, one wait state on reads
   logic        rd_pend_reg, rd_pend_next;
   logic [31:0] rdata_reg, rdata_next;
   always_comb
   begin
      ctrl_next    = ctrl_reg;
      rd_pend_next = avs_read && !rd_pend_reg;
      rdata_next   = rdata_reg;
      if (avs_write && avs_address == PCSD_OFS_CTRL)
         ctrl_next = avs_writedata[1:0];
      if (avs_read && !rd_pend_reg)
      begin
         unique case (avs_address)
            PCSD_OFS_STRAP: rdata_next = {26'h0, strap_done_reg, strap_reg};
            PCSD_OFS_CTRL:  rdata_next = {30'h0, ctrl_reg};
            PCSD_OFS_STAT:  rdata_next = {27'h0, simple_family, mode_two, big_endian, state_reg};
            default:        rdata_next = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg    <= PCSD_CTRL_RESET;
         rd_pend_reg <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
      end
      else
      begin
         ctrl_reg    <= ctrl_next;
         rd_pend_reg <= rd_pend_next;
         rdata_reg   <= rdata_next;
      end
   end
   assign avs_waitrequest = avs_read && !rd_pend_reg;
   assign avs_readdata    = rdata_reg;
endmodule : pcsd_top
`default_nettype wire

/* File: logic/pcsd_pkg.sv */
package pcsd_pkg;
   // ==========================================
   // Configuration straps
   localparam logic [2:0]  PCSD_IFSEL_SIMPLE   = 3'h7;
   localparam int          PCSD_ENDIAN_BIT     = 3;
   localparam int          PCSD_STRAP_SETTLE   = 2;
   // ==========================================
   // Controller window (128K byte)
   localparam int          PCSD_WIN_BITS       = 17;
   localparam logic [16:0] PCSD_MEM_LAST       = 17'h13FFF;
   localparam logic [16:0] PCSD_REG_FIRST      = 17'h1FFE0;
   localparam logic [16:0] PCSD_REG_LAST       = 17'h1FFFF;
   localparam int          PCSD_REG_WORDS      = 16;
   // ==========================================
   // Host slot map
   localparam logic [31:0] PCSD_S1_IO_BASE     = 32'h0800_0000;
   localparam logic [31:0] PCSD_S1_CTRL_BASE   = 32'h0900_0000;
   localparam logic [31:0] PCSD_S1_ATTR_BASE   = 32'h0A00_0000;
   localparam logic [31:0] PCSD_S2_IO_BASE     = 32'h0C00_0000;
   localparam logic [31:0] PCSD_S2_CTRL_BASE   = 32'h0D00_0000;
   localparam logic [31:0] PCSD_S2_ATTR_BASE   = 32'h0E00_0000;
   localparam logic [31:0] PCSD_S1_MEM_BASE    = 32'h6400_0000;
   localparam logic [31:0] PCSD_S2_MEM_BASE    = 32'h6800_0000;
   localparam int          PCSD_BUF_ALIASES    = 128;
   localparam int          PCSD_DIR_ALIASES    = 512;
   // ==========================================
   // Register bus offsets
   localparam logic [3:0]  PCSD_OFS_STRAP      = 4'h0;
   localparam logic [3:0]  PCSD_OFS_CTRL       = 4'h4;
   localparam logic [3:0]  PCSD_OFS_STAT       = 4'h8;
   localparam logic [1:0]  PCSD_CTRL_RESET     = 2'h0;
   // ==========================================
   // Refresh arbitration
   localparam int          PCSD_REFRESH_PERIOD = 16;
   localparam int          PCSD_REFRESH_LEN    = 2;
   typedef enum logic [1:0]
   {
      PCSD_IDLE  = 2'b00,
      PCSD_ARB   = 2'b01,
      PCSD_DONE  = 2'b11,
      PCSD_RELS  = 2'b10
   } pcsd_state_t;
endpackage : pcsd_pkg

/* File: logic/pcsd_mem_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pcsd_mem_if;
   logic        we;
   logic [16:0] addr;
   logic [15:0] wdata;
   logic [1:0]  be;
   logic [15:0] rdata;
   modport master (output we, addr, wdata, be, input rdata);
   modport slave  (input we, addr, wdata, be, output rdata);
endinterface : pcsd_mem_if
`default_nettype wire

/* File: logic/pcsd_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module pcsd_mem
(
   input  wire logic   clk,
   pcsd_mem_if.slave   mem
);
   // Display memory bytes 0..13FFFh as 40960 words, byte addressed; index by word
   logic [15:0] ram [0:40959];
   logic [15:0] rdata_reg;
   logic [15:0] widx;
   assign widx = mem.addr[16:1];
   always_ff @(posedge clk)
   begin
      if (mem.we && mem.be[0])
         ram[widx][7:0] <= mem.wdata[7:0];
      if (mem.we && mem.be[1])
         ram[widx][15:8] <= mem.wdata[15:8];
      rdata_reg <= ram[widx];
   end
   assign mem.rdata = rdata_reg;
endmodule : pcsd_mem
`default_nettype wire

/* File: testbench/pcsd_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module pcsd_assertions
   import pcsd_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        bus_style_strap,
   input wire logic [3:0]  configuration_straps,
   input wire logic        host_cs_n,
   input wire logic        host_wait_n,
   input wire logic        host_data_oe,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   // ==========
   // Strap snapshot, taken while straps are still held
   logic [2:0] cnt_reg;
   logic [4:0] cap_reg;
   logic       rd_ok;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   assign rd_ok = avs_read && !avs_waitrequest && cnt_reg == 3'h7;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) cnt_reg <= 3'h0;
      else if (cnt_reg != 3'h7) cnt_reg <= cnt_reg + 3'h1;
   always_ff @(posedge clk)
      if (cnt_reg == 3'h1) cap_reg <= {bus_style_strap, configuration_straps};
   // ==========
   // Properties
   a_strap_held: assert property (rd_ok && avs_address == PCSD_OFS_STRAP |-> avs_readdata[4:0] == cap_reg)
      else $error("strap readback");
   a_mode_stat: assert property (rd_ok && avs_address == PCSD_OFS_STAT && cap_reg[2:0] == 3'h7
      |-> avs_readdata[4:2] == {1'b1, cap_reg[4:3]}) else $error("mode readback");
   a_sync_delay: assert property ($fell(host_cs_n) |-> host_wait_n [*2])
      else $error("wait before sync");
   a_wait_start: assert property ($fell(host_cs_n) |-> ##[2:3] !host_wait_n)
      else $error("no wait");
   a_wait_bound: assert property ($fell(host_wait_n) |-> ##[2:40] host_wait_n)
      else $error("wait too long");
   a_oe_after_wait: assert property (host_data_oe |-> host_wait_n)
      else $error("oe in wait");
   a_idle_no_wait: assert property (host_cs_n [*4] |-> host_wait_n)
      else $error("idle wait");
   a_avs_read: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read timing");
   c_host_read: cover property ($rose(host_data_oe));
   c_wait: cover property ($rose(host_wait_n));
   c_stat: cover property (rd_ok && avs_address == PCSD_OFS_STAT);
endmodule : pcsd_assertions
bind pcsd_top pcsd_assertions pcsd_assertions_i (.*);
`default_nettype wire

/* File: testbench/pcsd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pcsd_host_model
(
   input  wire logic        clk,
   input  wire logic        host_wait_n,
   input  wire logic        host_data_oe,
   input  wire logic [15:0] host_data_out,
   output var  logic        host_cs_n,
   output var  logic        host_rd_n,
   output var  logic        host_we0_n,
   output var  logic        host_we1_n,
   output var  logic [25:0] host_addr,
   output var  logic [15:0] host_data_in,
   output var  logic        host_bus_clock
);
   logic mode2 = 1'b1;
   // ==========
   // Bus clock free runs, phase unrelated to clk
   initial
   begin
      {host_cs_n, host_rd_n, host_we0_n, host_we1_n, host_addr, host_data_in} = {4'hF, 42'h0};
      host_bus_clock = 1'b0;
      #13 forever #40 host_bus_clock = ~host_bus_clock;
   end
   // ==========
   // One cycle through a single buffer in the bus mode that mode2 selects
   task automatic access(input logic [31:0] a, input logic wr, input logic [15:0] d,
                         output logic [15:0] q, output logic ok);
      int i, j;
      i = 0;
      j = 0;
      @(posedge clk);
      // Card regions never strobe the controller
      host_cs_n <= !(a[31:24] inside {8'h09, 8'h0D} || a[31:26] inside {6'h19, 6'h1A});
      host_addr <= a[25:0];
      host_data_in <= d;
      {host_rd_n, host_we0_n, host_we1_n} <= {wr, !wr, !wr && !mode2};
      do @(posedge clk); while (host_wait_n !== 1'b0 && ++i < 8);
      do @(posedge clk); while (host_wait_n !== 1'b1 && ++j < 60);
      ok = i < 8 && j < 60 && (wr || host_data_oe === 1'b1);
      q = host_data_out;
      {host_cs_n, host_rd_n, host_we0_n, host_we1_n} <= 4'hF;
      host_data_in <= ~d; // Released bus shows no stale data
      repeat (3) @(posedge clk);
   endtask : access
endmodule : pcsd_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import pcsd_pkg::*;
;
   logic        clk, rst_n, bus_style_strap, host_cs_n, host_rd_n, host_we0_n, host_we1_n;
   logic        host_data_oe, host_wait_n, host_bus_clock, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  configuration_straps, avs_address;
   logic [25:0] host_addr;
   logic [15:0] host_data_in, host_data_out, q16, d;
   logic [31:0] avs_writedata, avs_readdata, q32;
   logic [15:0] exp_mem [logic [16:0]];
   int          n_fail, compares;
   localparam logic [31:0] BASES [4] = '{PCSD_S1_CTRL_BASE, PCSD_S2_CTRL_BASE, PCSD_S1_MEM_BASE, PCSD_S2_MEM_BASE};
   localparam logic [16:0] CORNERS [5] = '{17'h0, 17'h13FFE, 17'h14000, 17'h1FFE0, 17'h1FFFE};
   pcsd_top        pcsd_top_i (.*);
   pcsd_host_model pcsd_host_model_i (.*);
   // ==========
   // Helpers
   function automatic logic [31:0] sys_addr(logic [16:0] ofs);
      int k;
      k = $urandom % 4;
      return BASES[k] + (($urandom % (k < 2 ? PCSD_BUF_ALIASES : PCSD_DIR_ALIASES)) << PCSD_WIN_BITS) + ofs;
   endfunction : sys_addr
   function automatic logic [15:0] expect_rd(logic [16:0] ofs);
      return (ofs > PCSD_MEM_LAST && ofs < PCSD_REG_FIRST) ? 16'h0 : exp_mem[ofs];
   endfunction : expect_rd
   task automatic conclude();
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
      int i;
      i = 0;
      @(posedge clk);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, wd};
      do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++i < 20);
      q = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
      if (i >= 20)
      begin
         n_fail++;
         conclude();
      end
   endtask : avs
   // ==========
   // Stimulus
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      logic [16:0] ofs;
      logic        okw, ok;
      {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {bus_style_strap, configuration_straps} = '0;
      void'($urandom(32'h811c82f8));
      for (int p = 0; p < 4; p++)
      begin
         rst_n <= 1'b0;
         bus_style_strap <= p[0];
         configuration_straps <= {p[1], 3'h7};
         repeat (8) @(posedge clk);
         rst_n <= 1'b1;
         repeat (4) @(posedge clk);
         pcsd_host_model_i.mode2 = p[0];
         bus_style_strap <= ~p[0];
         configuration_straps <= 4'($urandom);
         avs(1'b1, PCSD_OFS_STRAP, $urandom, q32);
         avs(1'b0, PCSD_OFS_STRAP, 32'h0, q32);
         cmp(q32[4:0], {p[0], p[1], 3'h7});
         avs(1'b0, PCSD_OFS_STAT, 32'h0, q32);
         cmp(q32[4:2], {1'b1, p[0], p[1]});
         avs(1'b0, PCSD_OFS_CTRL, 32'h0, q32);
         cmp(q32[1:0], PCSD_CTRL_RESET);
         avs(1'b1, PCSD_OFS_CTRL, 32'h1, q32);
         avs(1'b0, PCSD_OFS_CTRL, 32'h0, q32);
         cmp(q32[1:0], 2'h1);
         avs(1'b1, PCSD_OFS_CTRL, 32'h0, q32);
         // Memory survives reset: an endian change shows as swapped bytes
         if (p > 0)
         begin
            pcsd_host_model_i.access(sys_addr(17'h0), 1'b0, 16'h0, q16, ok);
            cmp(q16, p == 2 ? {exp_mem[17'h0][7:0], exp_mem[17'h0][15:8]} : exp_mem[17'h0]);
         end
         avs(1'b0, 4'hC, 32'h0, q32);
         cmp(q32, 32'h0);
         for (int k = 0; k < 12; k++)
         begin
            ofs = k < 5 ? CORNERS[k] : 17'($urandom) & 17'h1FFFE;
            d = 16'($urandom);
            pcsd_host_model_i.access(sys_addr(ofs), 1'b1, d, q16, okw);
            exp_mem[ofs] = d;
            pcsd_host_model_i.access(sys_addr(ofs), 1'b0, 16'h0, q16, ok);
            cmp({okw, ok}, 2'b11);
            cmp(q16, expect_rd(ofs));
         end
      end
      conclude();
   end
endmodule : tb_top
`default_nettype wire
